/* rtl/sfc_command_core.sv */
// serial slave command core of a 128K x 8 ferroelectric memory
`default_nettype none

// Overview of operation
// - status bit 7 is the status protect flag, written and read by status commands
// - status bits 6..4 are spare storage, written and read back unchanged
// - status bits 3..2 are block protect selectors, writable and readable
// - status bit 1 is the write enable latch, set only by set-latch and never written by status write
// - latch clears at reset, on clear-latch, and on wake from either sleep mode
// - latch stays set after status, serial-number and special-sector writes
// - status bit 0 always reads zero and is never written
// - sixteen commands, each picked by an eight-bit opcode after chip select falls
// - set-latch 06, clear-latch 04, status read 05, status write 01
// - array read 03, array write 02, fast read 0b, deep sleep ba, hibernate b9
// - ident 9f, unique ident 4c, serial c2/c3, sector 42/4b/49; ce cf cc reserved
// - only defined opcodes; a partial opcode before deselect does nothing
// - status and array writes act only while the write enable latch is set
// - status read shifts the status byte out repeatedly, serial input ignored
// - status write takes one byte and keeps only the stored bits
// - array read takes a 24-bit address, top 7 ignored, then streams bytes
// - reads advance the address per byte and wrap from top to zero
// - fast read inserts eight dummy clocks after the address before data
// - array write takes address then bytes, each committed on its eighth bit
// - ident read sends 32 bits, maker first, then holds the last bit
// - ident read ignores serial input; the ident value is fixed
// - deselected: output released and inputs ignored
// - input sampled on rising clock, output changed on falling clock
// - protect pair: none, upper quarter, upper half, whole array
// - latch low blocks all writes; status blocked if protect flag and pin low
module sfc_command_core
    import sfc_pkg::*;
#(
    parameter logic [31:0] IDENT_WORD = 32'h5ac3317e, // arbitrary value
    parameter int HIBERNATE_CYCLES = HIBERNATE_RECOVER_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic spiClk,
    input wire logic chipSelect_n,
    input wire logic serialIn,
    input wire logic writeProtect_n,
    output logic serialOut,
    output logic serialOutEn,
    output logic deviceAsleep
);

    // ==========================================================
    // reset release
    logic [1:0] rstPipe_q;
    logic rstN;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end

    assign rstN = rstPipe_q[1];

    // ==========================================================
    // declarations shared by both domains
    logic armed_q, sleepKind_q, asleep_q, wakeTgl_q;
    logic csSync, armedSync, kindSync, asleepLink, wakeTglLink, wpLink_n;

    // ==========================================================
    // clock domain: pin and link crossings
    sfc_bit_sync #(.RESET_VAL(1'b1)) csSyncInst (.clk(clock), .rst_n(rstN), .d(chipSelect_n),
        .q(csSync));
    sfc_bit_sync #(.RESET_VAL(1'b0)) armedSyncInst (.clk(clock), .rst_n(rstN), .d(armed_q),
        .q(armedSync));
    sfc_bit_sync #(.RESET_VAL(1'b0)) kindSyncInst (.clk(clock), .rst_n(rstN), .d(sleepKind_q),
        .q(kindSync));

    // ==========================================================
    // clock domain: low power modes
    sfc_power_state_t pwrState_q;
    logic csPrev_q, consumed_q, hibKind_q;
    logic [RECOVER_CNT_BITS-1:0] recoverCnt_q;
    logic csRise, csFall;

    assign csRise = csSync & ~csPrev_q;
    assign csFall = ~csSync & csPrev_q;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            csPrev_q <= 1'b1;
        end else begin
            csPrev_q <= csSync;
        end
    end

    // an armed request survives the frame end, so it is consumed once to keep the
    // wake frame (no clocks) from putting the part straight back to sleep
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            consumed_q <= 1'b0;
        end else if (!armedSync) begin
            consumed_q <= 1'b0;
        end else if (pwrState_q == PS_AWAKE && csRise) begin
            consumed_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            pwrState_q <= PS_AWAKE;
            hibKind_q <= 1'b0;
            recoverCnt_q <= '0;
            wakeTgl_q <= 1'b0;
        end else begin
            case (pwrState_q)
                PS_AWAKE: begin
                    if (csRise && armedSync && !consumed_q) begin
                        pwrState_q <= PS_ASLEEP;
                        hibKind_q <= kindSync;
                    end
                end
                PS_ASLEEP: begin
                    if (csFall) begin
                        pwrState_q <= PS_RECOVER;
                        recoverCnt_q <= hibKind_q ? RECOVER_CNT_BITS'(HIBERNATE_CYCLES)
                                                  : RECOVER_CNT_BITS'(DEEP_SLEEP_RECOVER_CYCLES);
                    end
                end
                PS_RECOVER: begin
                    if (recoverCnt_q <= RECOVER_CNT_BITS'(1)) begin
                        pwrState_q <= PS_AWAKE;
                        wakeTgl_q <= ~wakeTgl_q;
                    end else begin
                        recoverCnt_q <= recoverCnt_q - RECOVER_CNT_BITS'(1);
                    end
                end
                default: pwrState_q <= PS_AWAKE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            asleep_q <= 1'b0;
        end else begin
            asleep_q <= (pwrState_q != PS_AWAKE);
        end
    end

    assign deviceAsleep = asleep_q;

    // ==========================================================
    // link domain: crossings into the serial clock
    sfc_bit_sync #(.RESET_VAL(1'b0)) asleepSyncInst (.clk(spiClk), .rst_n(rstN), .d(asleep_q),
        .q(asleepLink));
    sfc_bit_sync #(.RESET_VAL(1'b0)) wakeSyncInst (.clk(spiClk), .rst_n(rstN), .d(wakeTgl_q),
        .q(wakeTglLink));
    // protect pin settles over the op-code, well before the status byte ends
    sfc_bit_sync #(.RESET_VAL(1'b1)) wpSyncInst (.clk(spiClk), .rst_n(rstN), .d(writeProtect_n),
        .q(wpLink_n));

    // ==========================================================
    // link domain: frame decode
    sfc_link_state_t linkState_q;
    logic [4:0] bitCnt_q;
    logic [7:0] shiftIn_q, cmd_q, txByte_q;
    logic [16:0] addr_q, addrIn;
    logic [7:2] statusNv_q;
    logic wel_q, wakeSeen_q;
    logic [7:0] mem [MEM_WORDS];
    logic [7:0] rxByte, statusByte;
    logic frameClr, byteDone, opcodeLive, welSetEv, welClrEv, wakeClr, sleepEv;
    logic statusWrEv, memWrEv;

    // deselect holds the whole frame in reset, so a cut op-code leaves nothing behind
    assign frameClr = chipSelect_n | ~rstN;
    assign rxByte = {shiftIn_q[6:0], serialIn};
    assign addrIn = {addr_q[15:0], serialIn};
    assign statusByte = {statusNv_q, wel_q, 1'b0};
    assign byteDone = (bitCnt_q == BYTE_LAST_BIT);
    assign opcodeLive = (linkState_q == LS_OPCODE) && byteDone && !asleepLink;
    assign welSetEv = opcodeLive && (rxByte == OPC_SET_LATCH);
    assign welClrEv = opcodeLive && (rxByte == OPC_CLEAR_LATCH);
    assign sleepEv = opcodeLive && (rxByte == OPC_DEEP_SLEEP || rxByte == OPC_HIBERNATE);
    assign wakeClr = (wakeTglLink != wakeSeen_q);
    assign statusWrEv = (linkState_q == LS_STATUS_WRITE) && byteDone && wel_q
                        && !(statusNv_q[STATUS_PROTECT_BIT] && !wpLink_n);
    assign memWrEv = (linkState_q == LS_WRITE_DATA) && byteDone && wel_q
                     && !sfc_shielded(statusNv_q[BLOCK_PROTECT_HI_BIT:BLOCK_PROTECT_LO_BIT],
                                      addr_q);

    always_ff @(posedge spiClk or posedge frameClr) begin
        if (frameClr) begin
            linkState_q <= LS_OPCODE;
            bitCnt_q <= 5'h00;
            shiftIn_q <= 8'h00;
            cmd_q <= 8'h00;
            addr_q <= 17'h00000;
            txByte_q <= 8'h00;
        end else begin
            shiftIn_q <= rxByte;
            case (linkState_q)
                LS_OPCODE: begin
                    bitCnt_q <= byteDone ? 5'h00 : bitCnt_q + 5'h01;
                    if (byteDone) begin
                        cmd_q <= rxByte;
                        if (asleepLink) begin
                            linkState_q <= LS_IGNORE;
                        end else begin
                            case (rxByte)
                                OPC_STATUS_READ: begin
                                    linkState_q <= LS_STATUS_READ;
                                    txByte_q <= statusByte;
                                end
                                OPC_STATUS_WRITE: linkState_q <= LS_STATUS_WRITE;
                                OPC_ARRAY_READ, OPC_ARRAY_WRITE, OPC_FAST_READ: begin
                                    linkState_q <= LS_ADDRESS;
                                end
                                OPC_IDENT_READ: linkState_q <= LS_IDENT;
                                // latch, sleep and the unmodelled commands end here
                                default: linkState_q <= LS_IGNORE;
                            endcase
                        end
                    end
                end
                LS_ADDRESS: begin
                    addr_q <= addrIn;
                    if (bitCnt_q == ADDR_LAST_BIT) begin
                        bitCnt_q <= 5'h00;
                        case (cmd_q)
                            OPC_ARRAY_READ: begin
                                linkState_q <= LS_READ_DATA;
                                txByte_q <= mem[addrIn];
                                addr_q <= addrIn + 17'h00001;
                            end
                            OPC_FAST_READ: linkState_q <= LS_DUMMY;
                            default: linkState_q <= LS_WRITE_DATA;
                        endcase
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                LS_DUMMY: begin
                    bitCnt_q <= byteDone ? 5'h00 : bitCnt_q + 5'h01;
                    if (byteDone) begin
                        linkState_q <= LS_READ_DATA;
                        txByte_q <= mem[addr_q];
                        addr_q <= addr_q + 17'h00001;
                    end
                end
                LS_READ_DATA: begin
                    bitCnt_q <= byteDone ? 5'h00 : bitCnt_q + 5'h01;
                    if (byteDone) begin
                        txByte_q <= mem[addr_q];
                        addr_q <= addr_q + 17'h00001;
                    end
                end
                LS_WRITE_DATA: begin
                    bitCnt_q <= byteDone ? 5'h00 : bitCnt_q + 5'h01;
                    if (byteDone) begin
                        addr_q <= addr_q + 17'h00001;
                    end
                end
                LS_STATUS_READ: begin
                    bitCnt_q <= byteDone ? 5'h00 : bitCnt_q + 5'h01;
                    if (byteDone) begin
                        txByte_q <= statusByte;
                    end
                end
                LS_STATUS_WRITE: begin
                    bitCnt_q <= byteDone ? 5'h00 : bitCnt_q + 5'h01;
                    if (byteDone) begin
                        linkState_q <= LS_IGNORE;
                    end
                end
                LS_IDENT: begin
                    if (bitCnt_q != IDENT_LAST_BIT) begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                default: begin
                    linkState_q <= LS_IGNORE;
                end
            endcase
        end
    end

    // ==========================================================
    // link domain: array storage, no reset on data
    always_ff @(posedge spiClk) begin
        if (memWrEv) begin
            mem[addr_q] <= rxByte;
        end
    end

    // ==========================================================
    // link domain: status register
    always_ff @(posedge spiClk or negedge rstN) begin
        if (!rstN) begin
            statusNv_q <= STATUS_NV_RESET;
        end else if (statusWrEv) begin
            statusNv_q <= rxByte[7:2];
        end
    end

    // set wins over a coincident wake clear
    always_ff @(posedge spiClk or negedge rstN) begin
        if (!rstN) begin
            wel_q <= WRITE_ENABLE_RESET;
            wakeSeen_q <= 1'b0;
        end else begin
            wakeSeen_q <= wakeTglLink;
            if (welSetEv) begin
                wel_q <= 1'b1;
            end else if (welClrEv || wakeClr) begin
                wel_q <= 1'b0;
            end
            // status and array writes leave the latch alone
        end
    end

    // any clock after a sleep op-code withdraws the request
    always_ff @(posedge spiClk or negedge rstN) begin
        if (!rstN) begin
            armed_q <= 1'b0;
            sleepKind_q <= 1'b0;
        end else begin
            armed_q <= sleepEv;
            if (sleepEv) begin
                sleepKind_q <= (rxByte == OPC_HIBERNATE);
            end
        end
    end

    // ==========================================================
    // link domain: serial output on the falling edge
    logic soData_q;
    logic soEn_q;
    always_ff @(negedge spiClk or posedge frameClr) begin
        if (frameClr) begin
            soData_q <= 1'b0;
            soEn_q <= 1'b0;
        end else begin
            case (linkState_q)
                LS_STATUS_READ, LS_READ_DATA: begin
                    soData_q <= txByte_q[3'h7 - bitCnt_q[2:0]];
                    soEn_q <= 1'b1;
                end
                LS_IDENT: begin
                    soData_q <= IDENT_WORD[IDENT_LAST_BIT - bitCnt_q];
                    soEn_q <= 1'b1;
                end
                default: soEn_q <= 1'b0;
            endcase
        end
    end

    assign serialOut = soData_q;
    assign serialOutEn = soEn_q;

endmodule : sfc_command_core

`default_nettype wire

/* rtl/sfc_pkg.sv */
// opcodes, status layout, timing constants and helpers of the serial memory command core
`default_nettype none

package sfc_pkg;

    // ==========================================================
    // array geometry
    localparam int ADDR_BITS = 17;
    localparam int MEM_WORDS = 131072;

    // ==========================================================
    // opcodes
    localparam logic [7:0] OPC_SET_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
    localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OPC_FAST_READ = 8'h0b;
    localparam logic [7:0] OPC_DEEP_SLEEP = 8'hba;
    localparam logic [7:0] OPC_HIBERNATE = 8'hb9;
    localparam logic [7:0] OPC_IDENT_READ = 8'h9f;
    localparam logic [7:0] OPC_UNIQUE_IDENT_READ = 8'h4c;
    localparam logic [7:0] OPC_SERIAL_NUMBER_WRITE = 8'hc2;
    localparam logic [7:0] OPC_SERIAL_NUMBER_READ = 8'hc3;
    localparam logic [7:0] OPC_SPECIAL_SECTOR_WRITE = 8'h42;
    localparam logic [7:0] OPC_SPECIAL_SECTOR_READ = 8'h4b;
    localparam logic [7:0] OPC_FAST_SPECIAL_SECTOR_READ = 8'h49;
    localparam logic [7:0] OPC_RESERVED_A = 8'hce;
    localparam logic [7:0] OPC_RESERVED_B = 8'hcf;
    localparam logic [7:0] OPC_RESERVED_C = 8'hcc;

    // ==========================================================
    // status register layout and reset values
    localparam int STATUS_PROTECT_BIT = 7;
    localparam int BLOCK_PROTECT_HI_BIT = 3;
    localparam int BLOCK_PROTECT_LO_BIT = 2;
    localparam int WRITE_ENABLE_BIT = 1;
    localparam logic [7:2] STATUS_NV_RESET = 6'h00;
    localparam logic WRITE_ENABLE_RESET = 1'b0;

    // ==========================================================
    // bit counts inside a frame
    localparam logic [4:0] BYTE_LAST_BIT = 5'h07;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
    localparam logic [4:0] IDENT_LAST_BIT = 5'h1f;

    // ==========================================================
    // timing
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int DEEP_SLEEP_RECOVER_NS = 10000;
    localparam int HIBERNATE_RECOVER_NS = 450000;
    localparam int DEEP_SLEEP_RECOVER_CYCLES = DEEP_SLEEP_RECOVER_NS / CLOCK_PERIOD_NS;
    localparam int HIBERNATE_RECOVER_CYCLES = HIBERNATE_RECOVER_NS / CLOCK_PERIOD_NS;
    localparam int RECOVER_CNT_BITS = 14;

    // ==========================================================
    // state types
    typedef enum logic [3:0] {
        LS_OPCODE,
        LS_ADDRESS,
        LS_DUMMY,
        LS_READ_DATA,
        LS_WRITE_DATA,
        LS_STATUS_READ,
        LS_STATUS_WRITE,
        LS_IDENT,
        LS_IGNORE
    } sfc_link_state_t;

    typedef enum logic [1:0] {
        PS_AWAKE,
        PS_ASLEEP,
        PS_RECOVER
    } sfc_power_state_t;

    // ==========================================================
    // helpers
    function automatic logic sfc_shielded(input logic [1:0] bp, input logic [16:0] addr);
        case (bp)
            2'h0: sfc_shielded = 1'b0;
            2'h1: sfc_shielded = (addr[16:15] == 2'h3);
            2'h2: sfc_shielded = addr[16];
            default: sfc_shielded = 1'b1;
        endcase
    endfunction : sfc_shielded

endpackage : sfc_pkg

`default_nettype wire

/* rtl/sfc_bit_sync.sv */
// two-flop level synchroniser with a constant reset value
`default_nettype none

module sfc_bit_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // ==========================================================
    // the first stage feeds the second and nothing else
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : sfc_bit_sync

`default_nettype wire

/* sim/sfc_command_core_asserts.sv */
// port-level checks of the serial memory command core
`default_nettype none

module sfc_command_core_asserts
    import sfc_pkg::*;
#(
    parameter logic [31:0] IDENT_WORD = 32'h0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic spiClk,
    input wire logic chipSelect_n,
    input wire logic serialIn,
    input wire logic writeProtect_n,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic deviceAsleep
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // frame tracking
    logic [15:0] bitCnt_q;
    logic [7:0] opc_q;
    logic soRise_q;
    always_ff @(posedge spiClk or posedge chipSelect_n) begin
        if (chipSelect_n) begin
            bitCnt_q <= 16'h0000;
            opc_q <= 8'h00;
        end else begin
            // saturate so long streams never look like a fresh opcode
            if (bitCnt_q != 16'hffff) begin
                bitCnt_q <= bitCnt_q + 16'h0001;
            end
            if (bitCnt_q < 16'h0008) begin
                opc_q <= {opc_q[6:0], serialIn};
            end
        end
    end
    always_ff @(posedge spiClk) begin
        soRise_q <= serialOut;
    end
    // ==========================================================
    // assertions
    a_deselect_release: assert property (@(posedge clock) disable iff (!reset_n)
        chipSelect_n |-> !serialOutEn) else $error("drive while deselected");
    a_opcode_quiet: assert property (@(posedge spiClk) disable iff (!reset_n)
        bitCnt_q < 16'h0008 |-> !serialOutEn) else $error("drive inside opcode");
    a_status_drive: assert property (@(posedge spiClk) disable iff (!reset_n)
        bitCnt_q == 16'h0008 && opc_q == OPC_STATUS_READ && !deviceAsleep |-> serialOutEn)
        else $error("status not driven");
    a_status_zero: assert property (@(posedge spiClk) disable iff (!reset_n)
        bitCnt_q[2:0] == 3'h7 && bitCnt_q > 16'h0008 && opc_q == OPC_STATUS_READ
        && !deviceAsleep |-> !serialOut) else $error("status bit 0 set");
    a_ident_order: assert property (@(posedge spiClk) disable iff (!reset_n)
        bitCnt_q >= 16'h0008 && bitCnt_q <= 16'h0027 && opc_q == OPC_IDENT_READ
        && !deviceAsleep |-> serialOut == IDENT_WORD[6'd39 - bitCnt_q[5:0]])
        else $error("ident bit wrong");
    a_ident_hold: assert property (@(posedge spiClk) disable iff (!reset_n)
        bitCnt_q > 16'h0027 && opc_q == OPC_IDENT_READ && !deviceAsleep
        |-> serialOut == IDENT_WORD[0]) else $error("ident last bit not held");
    a_out_on_fall: assert property (@(negedge spiClk) disable iff (!reset_n || chipSelect_n)
        serialOut == soRise_q) else $error("output moved while clock high");
    a_asleep_quiet: assert property (@(posedge clock) disable iff (!reset_n)
        deviceAsleep |-> !serialOutEn) else $error("drive while asleep");
    a_wake_bound: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(chipSelect_n) && deviceAsleep |-> ##[1:300] !deviceAsleep)
        else $error("no wake");
    c_status: cover property (@(posedge spiClk) bitCnt_q == 16'h0010 && opc_q == OPC_STATUS_READ);
    c_ident: cover property (@(posedge spiClk) bitCnt_q == 16'h0028 && opc_q == OPC_IDENT_READ);
    c_sleep: cover property (@(posedge clock) $rose(deviceAsleep));
endmodule : sfc_command_core_asserts

bind sfc_command_core sfc_command_core_asserts #(.IDENT_WORD(IDENT_WORD)) u_chk (
    .clock(clock), .reset_n(reset_n), .spiClk(spiClk), .chipSelect_n(chipSelect_n),
    .serialIn(serialIn), .writeProtect_n(writeProtect_n), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .deviceAsleep(deviceAsleep));

`default_nettype wire

/* sim/sfc_spi_host.sv */
// host side of the serial link: framing and bit shifting, mode 0
`default_nettype none

module sfc_spi_host (
    output logic spiClk,
    output logic chipSelect_n,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spiClk = 1'b0;
        chipSelect_n = 1'b1;
        serialIn = 1'b0;
    end
    task automatic frame_start;
        chipSelect_n = 1'b0;
        #24;
    endtask : frame_start
    // no clock edge after the last fall, so a sleep opcode is not withdrawn
    task automatic frame_end;
        #24;
        chipSelect_n = 1'b1;
        serialIn = ~serialIn;
        #24;
    endtask : frame_end
    // an undriven device line reads as unknown, never as a lucky level
    task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
        rx = 8'hxx;
        for (int i = 7; i > 7 - nBits; i--) begin
            serialIn = tx[i];
            #24;
            spiClk = 1'b1;
            rx[i] = serialOutEn ? serialOut : 1'bx;
            #24;
            spiClk = 1'b0;
        end
    endtask : xfer
endmodule : sfc_spi_host

`default_nettype wire

/* sim/test_sfc_command_core.sv */
// self-checking bench of the serial memory command core
`default_nettype none

module test_sfc_command_core
    import sfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDENT = 32'h3c96a55b; // arbitrary value
    localparam logic [7:0] OTHER [9] = '{8'hc2, 8'h42, 8'hce, 8'hcf, 8'hcc, 8'h4c, 8'hc3,
        8'h4b, 8'h49};
    logic clock, reset_n, writeProtect_n, spiClk, chipSelect_n, serialIn;
    wire logic serialOut, serialOutEn, deviceAsleep;
    int mismatches = 0;
    int check_count = 0;
    logic [7:0] rxq[$];
    logic [7:0] rxCut;
    sfc_command_core #(.IDENT_WORD(IDENT), .HIBERNATE_CYCLES(40)) u_dut (.clock(clock),
        .reset_n(reset_n), .spiClk(spiClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
        .writeProtect_n(writeProtect_n), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .deviceAsleep(deviceAsleep));
    sfc_spi_host u_host (.spiClk(spiClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : settle
    task automatic send(input logic [7:0] b[$]);
        logic [7:0] r;
        rxq = {};
        settle(1);
        u_host.frame_start();
        foreach (b[i]) begin
            u_host.xfer(b[i], 8, r);
            rxq.push_back(r);
        end
        u_host.frame_end();
    endtask : send
    task automatic stat(input logic [7:0] exp);
        send('{OPC_STATUS_READ, 8'h00, 8'h00});
        check(rxq[1], exp);
        check(rxq[2], exp);
    endtask : stat
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // the whole sequence needs well under a millisecond
    initial begin
        #3ms;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        writeProtect_n = 1'b1;
        settle(5);
        reset_n = 1'b1;
        settle(3);
        stat(8'h00);
        send('{OPC_STATUS_WRITE, 8'hff});
        stat(8'h00);
        send('{OPC_SET_LATCH});
        send('{OPC_STATUS_WRITE, 8'hff});
        stat(8'hfe);
        settle(1);
        writeProtect_n = 1'b0;
        send('{OPC_STATUS_WRITE, 8'h00});
        stat(8'hfe);
        settle(1);
        writeProtect_n = 1'b1;
        send('{OPC_STATUS_WRITE, 8'h00});
        stat(8'h02);
        $display("status test done");
        send('{OPC_ARRAY_WRITE, 8'hff, 8'h7f, 8'hfe, 8'h11, 8'h22, 8'h33});
        send('{OPC_STATUS_WRITE, 8'h04});
        send('{OPC_ARRAY_WRITE, 8'hff, 8'h7f, 8'hfe, 8'h44, 8'h55, 8'h66});
        send('{OPC_ARRAY_READ, 8'hff, 8'h7f, 8'hfe, 8'h00, 8'h00, 8'h00});
        check(rxq[4], 8'h44);
        check(rxq[5], 8'h55);
        check(rxq[6], 8'h33);
        send('{OPC_STATUS_WRITE, 8'h00});
        send('{OPC_ARRAY_WRITE, 8'h01, 8'hff, 8'hff, 8'h5a, 8'h3c});
        send('{OPC_FAST_READ, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00});
        check(rxq[5], 8'h5a);
        check(rxq[6], 8'h3c);
        send('{OPC_CLEAR_LATCH});
        send('{OPC_ARRAY_WRITE, 8'h00, 8'h00, 8'h00, 8'h99});
        send('{OPC_ARRAY_READ, 8'h00, 8'h00, 8'h00, 8'h00});
        check(rxq[4], 8'h3c);
        $display("array test done");
        settle(1);
        u_host.frame_start();
        u_host.xfer(OPC_SET_LATCH, 7, rxCut);
        u_host.frame_end();
        stat(8'h00);
        send('{OPC_IDENT_READ, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
        for (int i = 0; i < 4; i++) begin
            check(rxq[i + 1], IDENT[31 - 8 * i -: 8]);
        end
        check(rxq[5], {8{IDENT[0]}});
        send('{OPC_SET_LATCH});
        foreach (OTHER[i]) begin
            send('{OTHER[i], 8'h00, 8'h00, 8'h00, 8'h00});
        end
        stat(8'h02);
        $display("ident test done");
        for (int i = 0; i < 2; i++) begin
            send('{OPC_SET_LATCH});
            send('{i == 0 ? OPC_HIBERNATE : OPC_DEEP_SLEEP});
            settle(10);
            check({7'h00, deviceAsleep}, 8'h01);
            send('{OPC_STATUS_READ, 8'h00});
            check(rxq[1], 8'hxx);
            settle(260);
            check({7'h00, deviceAsleep}, 8'h00);
            stat(8'h00);
        end
        $display("sleep test done");
        tally_and_finish();
    end
endmodule : test_sfc_command_core

`default_nettype wire
